// ==== verification/agsp_core_assertions.sv ====
// Concurrent checks on the sampling and readout ports
`timescale 1ns/100ps
module agsp_core_assertions
(
   // Clock and reset
   input logic clk_sys,
   input logic rst_n,
   // Watched ports
   input logic hold_a,
   input logic hold_b,
   input logic busy,
   input logic cs_n,
   input logic iface_choice_pin,
   input logic result_bus_oe,
   input logic first_channel_flag_oe
);
   localparam int CONV_MAX = 500;
   logic [9:0] busy_len;
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         busy_len <= 10'h0;
      else
         busy_len <= busy ? busy_len + 10'h1 : 10'h0;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_conv_end; busy ##1 !busy; endsequence
   sequence s_cs_idle; cs_n [*6]; endsequence
   sequence s_not_par; iface_choice_pin [*6]; endsequence
   ////////////////////////////////////////////////////////////////////
   grp_a_idle_a: assert property ($rose(hold_a) |-> !$past(busy))
      else $error("group A held during conversion");
   grp_b_idle_a: assert property ($rose(hold_b) |-> !$past(busy))
      else $error("group B held during conversion");
   one_group_a: assert property ((hold_a ^ hold_b) |-> !busy)
      else $error("conversion with one group held");
   both_held_a: assert property ((hold_a && hold_b) |-> busy)
      else $error("both groups held without conversion");
   busy_bound_a: assert property (busy |-> busy_len < CONV_MAX)
      else $error("busy longer than maximum");
   conv_end_a: assert property (s_conv_end |-> !hold_a && !hold_b)
      else $error("holds kept after conversion end");
   frame_float_a: assert property (s_cs_idle |->
      !result_bus_oe && !first_channel_flag_oe)
      else $error("outputs driven with select high");
   mode_float_a: assert property (s_not_par |->
      !result_bus_oe && !first_channel_flag_oe)
      else $error("outputs driven outside parallel mode");
endmodule // agsp_core_assertions

bind agsp_core agsp_core_assertions u_chk (.clk_sys, .rst_n, .hold_a,
   .hold_b, .busy, .cs_n, .iface_choice_pin, .result_bus_oe,
   .first_channel_flag_oe);

// ==== verification/agsp_core_tb.sv ====
// Self-checking bench for group sampling and parallel readout
`timescale 1ns/100ps
module agsp_core_tb;
   logic clk_sys = 0, rst_n = 0, hsel = 1, hwrite = 0;
   logic group_a_sample_trigger = 0, group_b_sample_trigger = 0;
   logic iface_choice_pin = 0, width_choice_pin = 0;
   logic [2:0] os_ratio_pin = 0, hsize = 3'h2;
   logic [1:0] htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0, rs = 32'he886, d;
   logic [127:0] ain_code = 0, nc, oc, ex;
   logic [17:0] q[$];
   wire hold_a, hold_b, busy, cs_n, rd_n, result_bus_oe, hready, hresp;
   wire first_channel_flag, first_channel_flag_oe, hreadyout, got_v;
   wire [15:0] result_bus;
   wire [31:0] hrdata;
   wire [17:0] got;
   int fail_count = 0, check_count = 0, m;
   always #4 clk_sys = ~clk_sys;
   assign hready = hreadyout;
   agsp_core dut (.clk_sys, .rst_n, .group_a_sample_trigger,
      .group_b_sample_trigger, .os_ratio_pin, .iface_choice_pin,
      .width_choice_pin, .ain_code, .hold_a, .hold_b, .busy, .cs_n, .rd_n,
      .result_bus, .result_bus_oe, .first_channel_flag,
      .first_channel_flag_oe, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hready, .hwdata, .hrdata, .hreadyout, .hresp);
   agsp_host host (.clk_sys, .result_bus, .result_bus_oe,
      .first_channel_flag, .first_channel_flag_oe, .cs_n, .rd_n, .got_v,
      .got);
   ////////////////////////////////////////////////////////////////////
   task tally_and_finish;
   begin
      $display("checks %0d fails %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
   begin
      check_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("FAIL %s exp %h got %h", n, e, g);
      end
   end
   endtask
   task tmo;
   begin
      fail_count++;
      $display("FAIL wait exp done got timeout");
      tally_and_finish();
   end
   endtask
   task rdy;
      int k;
   begin
      k = 0;
      do
      begin
         @(posedge clk_sys);
         k++;
      end
      while (hready !== 1'b1 && k < 50);
      if (k >= 50)
         tmo();
   end
   endtask
   task ahb(input logic w, input logic [31:0] a, wd, output logic [31:0] r);
   begin
      @(posedge clk_sys);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      rdy();
      htrans <= 2'h0;
      hwdata <= wd;
      rdy();
      r = hrdata;
   end
   endtask
   task rnd;
   begin
      for (int i = 0; i < 4; i++)
      begin
         rs = rs ^ (rs << 13);
         rs = rs ^ (rs >> 17);
         rs = rs ^ (rs << 5);
         nc[i*32 +: 32] = rs;
      end
      ain_code <= nc;
   end
   endtask
   task trig(input bit b);
   begin
      @(posedge clk_sys);
      if (b)
         group_b_sample_trigger <= 1'b1;
      else
         group_a_sample_trigger <= 1'b1;
      repeat (5) @(posedge clk_sys);
      group_a_sample_trigger <= 1'b0;
      group_b_sample_trigger <= 1'b0;
   end
   endtask
   task wait_busy(input logic lvl);
      int k;
   begin
      for (k = 0; k < 2000 && busy !== lvl; k++)
         @(posedge clk_sys);
      if (k >= 2000)
         tmo();
   end
   endtask
   // Expected words are queued before the host strobes them out
   task frame(input bit tied, input int n, input logic [127:0] c, int hi);
   begin
      for (int i = 0; i < n; i++)
      begin
         q.push_back({1'b1, i == 0, c[i*16 +: 16]});
         host.rd(tied, hi);
      end
   end
   endtask
   always @(posedge clk_sys)
   begin
      if (got_v === 1'b1)
         chk("word", {14'h0, q.pop_front()}, {14'h0, got});
   end
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      ahb(0, 32'h0, 32'h0, d);
      chk("ctrl", 32'h01f4_0001, d);
      ahb(0, 32'h10, 32'h0, d);
      chk("unmapped", 32'h0, d);
      chk("hresp", 0, hresp);
      hsel <= 1'b0;
      ahb(1, 32'h0, 32'h0, d);
      hsel <= 1'b1;
      ahb(0, 32'h0, 32'h0, d);
      chk("desel", 32'h01f4_0001, d);
      ahb(1, 32'h0, 32'h0004_0001, d);
      rnd();
      oc = nc;
      trig(0);
      chk("hold_a", 1, hold_a);
      chk("busy", 0, busy);
      rnd();
      trig(1);
      wait_busy(0);
      ex = {nc[127:64], oc[63:0]};
      frame(1, 8, ex, 4);
      $display("test 1 done");
      rnd();
      oc = nc;
      trig(1);
      chk("hold_b", 1, hold_b);
      chk("busy", 0, busy);
      rnd();
      trig(0);
      wait_busy(0);
      ex = {oc[127:64], nc[63:0]};
      host.sel(0);
      frame(0, 8, ex, 10);
      host.sel(1);
      repeat (8) @(posedge clk_sys);
      chk("oe", 0, {result_bus_oe, first_channel_flag_oe});
      $display("test 2 done");
      ahb(1, 32'h0, 32'h00c8_0001, d);
      rnd();
      trig(0);
      trig(1);
      chk("busy", 1, busy);
      host.sel(0);
      frame(0, 3, ex, 4);
      wait_busy(0);
      frame(0, 8, nc, 4);
      host.sel(1);
      $display("test 3 done");
      for (m = 0; m < 3; m++)
      begin
         iface_choice_pin <= (m > 0);
         width_choice_pin <= (m < 2);
         host.sel(0);
         repeat (4) @(posedge clk_sys);
         chk("bus_oe", (m == 0), result_bus_oe);
         ahb(0, 32'h4, 32'h0, d);
         chk("mode", m, d[9:8]);
         chk("par", (m == 0), d[3]);
         host.sel(1);
      end
      $display("test 4 done");
      iface_choice_pin <= 1'b0;
      ahb(1, 32'h0, 32'h00c8_0000, d);
      trig(0);
      chk("hold_dis", 0, hold_a);
      ahb(1, 32'h0, 32'h00c8_0001, d);
      os_ratio_pin <= 3'h3;
      rnd();
      trig(0);
      chk("os_hold_b", 1, hold_b);
      chk("os_busy", 1, busy);
      wait_busy(0);
      host.sel(0);
      frame(0, 8, nc, 4);
      host.sel(1);
      os_ratio_pin <= 3'h0;
      $display("test 5 done");
      tally_and_finish();
   end
endmodule // agsp_core_tb

// ==== verification/agsp_host.sv ====
// Host model stepping results out of the parallel bus
`timescale 1ns/100ps
module agsp_host
(
   // Clock
   input  wire        clk_sys,
   // Device outputs
   input  wire [15:0] result_bus,
   input  wire        result_bus_oe,
   input  wire        first_channel_flag,
   input  wire        first_channel_flag_oe,
   // Strobes and captured word
   output logic       cs_n,
   output logic       rd_n,
   output logic       got_v,
   output logic [17:0] got
);
   initial
   begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      got_v = 1'b0;
      got = 18'h0;
   end
   // Tied strobes only used here with one device on the bus
   task rd(input bit tied, input int hi);
   begin
      @(posedge clk_sys);
      rd_n <= 1'b0;
      if (tied)
         cs_n <= 1'b0;
      // Low long enough for the device synchroniser to see it
      repeat (5) @(posedge clk_sys);
      // Undriven lines show the inverse so a float cannot pass
      got <= {result_bus_oe & first_channel_flag_oe,
              first_channel_flag_oe ? first_channel_flag
                                    : ~first_channel_flag,
              result_bus_oe ? result_bus : ~result_bus};
      got_v <= 1'b1;
      @(posedge clk_sys);
      got_v <= 1'b0;
      rd_n <= 1'b1;
      if (tied)
         cs_n <= 1'b1;
      repeat (hi) @(posedge clk_sys);
   end
   endtask
   task sel(input logic v);
   begin
      @(posedge clk_sys);
      cs_n <= v;
      repeat (4) @(posedge clk_sys);
   end
   endtask
endmodule // agsp_host

// ==== verilog/agsp_core.v ====
// Two-group sample control, conversion timing and parallel result readout
//
// What this block does
// - Two groups with separate triggers; oversampling pins make group B follow group A
// - Group A rising edge holds channels 1-4
// - Group A alone starts conversion only with oversampling pins set
// - Group B rising edge holds channels 5-8
// - Both groups held starts internal-clock conversion
// - Busy high from start, within maximum time
// - Busy fall loads all eight results
// - Read after busy gives fresh results
// - Read during busy gives previous results
// - Mode pins pick parallel, byte or serial
// - Tied strobe falling drives result bus
// - First tied read gives channel 1, flag high
// - Later tied reads ascend, flag low
// - Select fall enables bus, reads advance data
// - First read gives channel 1, flag high
// - Flag low from second read until select rise
// - Frame end floats bus and flag
// - All eight channels converted and read out
//
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "agsp_regs.vh"

module agsp_core
#(
   parameter  CHANNELS = 8,
   parameter  RES_W    = 16,
   parameter  PTR_W    = 3
)
(
   // Clock and reset
   input  wire                       clk_sys,
   input  wire                       rst_n,
   // Sample triggers and oversampling pins
   input  wire                       group_a_sample_trigger,
   input  wire                       group_b_sample_trigger,
   input  wire [2:0]                 os_ratio_pin,
   // Interface choice pins
   input  wire                       iface_choice_pin,
   input  wire                       width_choice_pin,
   // Digitised front-end codes, channel 1 in the low bits
   input  wire [CHANNELS*RES_W-1:0]  ain_code,
   // Sample circuit and conversion status
   output reg                        hold_a,
   output reg                        hold_b,
   output reg                        busy,
   // Parallel readout strobes
   input  wire                       cs_n,
   input  wire                       rd_n,
   // Parallel readout outputs
   output reg  [RES_W-1:0]           result_bus,
   output reg                        result_bus_oe,
   output reg                        first_channel_flag,
   output reg                        first_channel_flag_oe,
   // AHB-Lite slave
   input  wire                       hsel,
   input  wire [31:0]                haddr,
   input  wire [1:0]                 htrans,
   input  wire                       hwrite,
   input  wire [2:0]                 hsize,
   input  wire                       hready,
   input  wire [31:0]                hwdata,
   output reg  [31:0]                hrdata,
   output wire                       hreadyout,
   output wire                       hresp
);

   localparam [1:0]  ST_IDLE = 2'h0;
   localparam [1:0]  ST_WAIT = 2'h1;
   localparam [1:0]  ST_CONV = 2'h2;

   // Integer count cut on purpose to the counter width
   localparam integer            CONV_CYCLES = `AGSP_CONV_CYCLES;
   localparam [`AGSP_CONV_W-1:0] CONV_MAX    = CONV_CYCLES[`AGSP_CONV_W-1:0];

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   wire [3:0]  strobe_level;
   wire [3:0]  strobe_rise;
   wire [3:0]  strobe_fall;
   wire [4:0]  mode_level;

   agsp_pin_sync
   #(
      .W    (4),
      .INIT ({`AGSP_CS_IDLE, `AGSP_CS_IDLE, 2'b00})
   )
   u_strobe_sync
   (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .pin_async ({rd_n, cs_n, group_b_sample_trigger,
                   group_a_sample_trigger}),
      .level     (strobe_level),
      .rise      (strobe_rise),
      .fall      (strobe_fall)
   );

   agsp_pin_sync
   #(
      .W    (5),
      .INIT (5'h00)
   )
   u_mode_sync
   (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .pin_async ({os_ratio_pin, width_choice_pin, iface_choice_pin}),
      .level     (mode_level),
      .rise      (),
      .fall      ()
   );

   wire        trig_a_rise = strobe_rise[0];
   wire        trig_b_rise = strobe_rise[1];
   wire        cs_low      = ~strobe_level[2];
   wire        cs_rise     = strobe_rise[2];
   wire        rd_fall     = strobe_fall[3];
   wire        iface_s     = mode_level[0];
   wire        width_s     = mode_level[1];
   wire [2:0]  os_s        = mode_level[4:2];

   ////////////////////////////////////////////////////////////////////////
   // Interface mode decode

   reg  [1:0]  iface_mode;

   always @*
   begin
      if (!iface_s)
         iface_mode = `AGSP_MODE_PAR;
      else if (width_s)
         iface_mode = `AGSP_MODE_BYTE;
      else
         iface_mode = `AGSP_MODE_SER;
   end

   wire        par_mode  = (iface_mode == `AGSP_MODE_PAR);
   // Oversampling makes group B follow group A, as if triggers were tied
   wire        two_group = (os_s == 3'h0);

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave

   reg  [31:0]                ctrl;
   reg                        wr_pend;
   reg  [`AGSP_ADDR_W-1:0]    wr_addr;
   wire [31:0]                status;

   wire        bus_take = hsel & hready & htrans[1];

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_pend <= 1'b0;
         wr_addr <= {`AGSP_ADDR_W{1'b0}};
         hrdata  <= 32'h0000_0000;
         ctrl    <= `AGSP_CTRL_RESET;
      end
      else
      begin
         if (wr_pend && (wr_addr == `AGSP_CTRL_ADDR))
            ctrl <= hwdata;
         wr_pend <= bus_take & hwrite;
         if (bus_take)
            wr_addr <= haddr[`AGSP_ADDR_W-1:0];
         if (bus_take && !hwrite)
         begin
            case (haddr[`AGSP_ADDR_W-1:0])
               `AGSP_CTRL_ADDR: hrdata <= ctrl;
               `AGSP_STAT_ADDR: hrdata <= status;
               default:         hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   wire                    conv_enable = ctrl[`AGSP_CTRL_EN_BIT];
   wire [`AGSP_CONV_W-1:0] conv_req    =
      ctrl[`AGSP_CTRL_CONV_MSB:`AGSP_CTRL_CONV_LSB];

   // Software may shorten conversion, never stretch past the maximum
   reg  [`AGSP_CONV_W-1:0] conv_len;

   always @*
   begin
      if (conv_req == {`AGSP_CONV_W{1'b0}})
         conv_len = {{(`AGSP_CONV_W-1){1'b0}}, 1'b1};
      else if (conv_req > CONV_MAX)
         conv_len = CONV_MAX;
      else
         conv_len = conv_req;
   end

   ////////////////////////////////////////////////////////////////////////
   // Sample hold and conversion sequencing

   reg  [1:0]              state;
   reg  [1:0]              next_state;
   reg  [`AGSP_CONV_W-1:0] conv_cnt;
   reg                     conv_done;

   wire take_a = trig_a_rise;
   wire take_b = two_group ? trig_b_rise : trig_a_rise;
   wire both_held_next = (hold_a | take_a) & (hold_b | take_b);

   always @*
   begin
      next_state = state;
      case (state)
         ST_IDLE:
         begin
            if (conv_enable && (take_a || take_b))
               next_state = both_held_next ? ST_CONV : ST_WAIT;
         end
         ST_WAIT:
         begin
            if (both_held_next)
               next_state = ST_CONV;
         end
         ST_CONV:
         begin
            if (conv_cnt == {{(`AGSP_CONV_W-1){1'b0}}, 1'b1})
               next_state = ST_IDLE;
         end
         default:
            next_state = ST_IDLE;
      endcase
   end

   reg  [RES_W-1:0]  held   [0:CHANNELS-1];
   reg  [RES_W-1:0]  result [0:CHANNELS-1];
   integer           i;

   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state     <= ST_IDLE;
         hold_a    <= 1'b0;
         hold_b    <= 1'b0;
         busy      <= 1'b0;
         conv_cnt  <= {`AGSP_CONV_W{1'b0}};
         conv_done <= 1'b0;
         for (i = 0; i < CHANNELS; i = i + 1)
         begin
            held[i]   <= {RES_W{1'b0}};
            result[i] <= {RES_W{1'b0}};
         end
      end
      else
      begin
         state     <= next_state;
         conv_done <= 1'b0;
         if (state != ST_CONV && (state != ST_IDLE || conv_enable))
         begin
            // Repeat edges on a group already held are ignored
            if (take_a && !hold_a)
            begin
               hold_a <= 1'b1;
               for (i = 0; i < CHANNELS/2; i = i + 1)
                  held[i] <= ain_code[i*RES_W +: RES_W];
            end
            if (take_b && !hold_b)
            begin
               hold_b <= 1'b1;
               for (i = CHANNELS/2; i < CHANNELS; i = i + 1)
                  held[i] <= ain_code[i*RES_W +: RES_W];
            end
         end
         if (state != ST_CONV && next_state == ST_CONV)
         begin
            busy     <= 1'b1;
            conv_cnt <= conv_len;
         end
         else if (state == ST_CONV)
         begin
            conv_cnt <= conv_cnt - {{(`AGSP_CONV_W-1){1'b0}}, 1'b1};
            if (next_state == ST_IDLE)
            begin
               busy      <= 1'b0;
               hold_a    <= 1'b0;
               hold_b    <= 1'b0;
               conv_done <= 1'b1;
               // Results change only here; reads mid-conversion see old
               for (i = 0; i < CHANNELS; i = i + 1)
                  result[i] <= held[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Parallel readout

   reg  [PTR_W-1:0]  rd_ptr;
   wire              read_step = par_mode & cs_low & rd_fall;

   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_ptr                <= {PTR_W{1'b0}};
         result_bus            <= {RES_W{1'b0}};
         result_bus_oe         <= 1'b0;
         first_channel_flag    <= 1'b0;
         first_channel_flag_oe <= 1'b0;
      end
      else
      begin
         // Select low drives the bus; tied strobes fall together
         result_bus_oe <= par_mode & cs_low;
         if (read_step)
         begin
            result_bus         <= result[rd_ptr];
            first_channel_flag <= (rd_ptr == {PTR_W{1'b0}});
            first_channel_flag_oe <= 1'b1;
            rd_ptr             <= rd_ptr + {{(PTR_W-1){1'b0}}, 1'b1};
         end
         if (cs_rise || !par_mode)
            first_channel_flag_oe <= 1'b0;
         if (conv_done)
            rd_ptr <= {PTR_W{1'b0}};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status word

   assign status = {18'h00000,
                    state,
                    2'h0,
                    iface_mode,
                    1'b0,
                    rd_ptr,
                    par_mode,
                    hold_b,
                    hold_a,
                    busy};

endmodule // agsp_core

// ==== verilog/agsp_pin_sync.v ====
// Two-stage pin synchroniser with edge detection on the settled level
`timescale 1ns/100ps

module agsp_pin_sync
#(
   parameter          W    = 1,
   parameter [W-1:0]  INIT = {W{1'b0}}
)
(
   // Clock and reset
   input  wire          clk_sys,
   input  wire          rst_n,
   // Pins and settled view
   input  wire [W-1:0]  pin_async,
   output wire [W-1:0]  level,
   output wire [W-1:0]  rise,
   output wire [W-1:0]  fall
);

   reg  [W-1:0]  meta;
   reg  [W-1:0]  settled;
   reg  [W-1:0]  prev;

   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta    <= INIT;
         settled <= INIT;
         prev    <= INIT;
      end
      else
      begin
         meta    <= pin_async;
         settled <= meta;
         prev    <= settled;
      end
   end

   assign level = settled;
   assign rise  = settled & ~prev;
   assign fall  = ~settled & prev;

endmodule // agsp_pin_sync

// ==== verilog/agsp_regs.vh ====
// Register map, field positions and timing counts of the sampling block
`ifndef AGSP_REGS_VH
`define AGSP_REGS_VH

// Byte addresses on the register bus
`define AGSP_CTRL_ADDR        8'h00
`define AGSP_STAT_ADDR        8'h04
`define AGSP_ADDR_W           8

// Control register fields
`define AGSP_CTRL_EN_BIT      0
`define AGSP_CTRL_CONV_LSB    16
`define AGSP_CTRL_CONV_MSB    27
`define AGSP_CONV_W           12

// Status register fields
`define AGSP_STAT_BUSY_BIT    0
`define AGSP_STAT_HOLDA_BIT   1
`define AGSP_STAT_HOLDB_BIT   2
`define AGSP_STAT_PAR_BIT     3
`define AGSP_STAT_PTR_LSB     4
`define AGSP_STAT_PTR_MSB     6
`define AGSP_STAT_MODE_LSB    8
`define AGSP_STAT_MODE_MSB    9
`define AGSP_STAT_STATE_LSB   12
`define AGSP_STAT_STATE_MSB   13

// Readout interface modes
`define AGSP_MODE_PAR         2'h0
`define AGSP_MODE_BYTE        2'h1
`define AGSP_MODE_SER         2'h2

// Timing
`define AGSP_CLK_PERIOD_NS    8
`define AGSP_CONV_TIME_MAX_NS 4000
`define AGSP_CONV_CYCLES      (`AGSP_CONV_TIME_MAX_NS / `AGSP_CLK_PERIOD_NS)

// Reset values
`define AGSP_CTRL_RESET       32'h01f4_0001
`define AGSP_CS_IDLE          1'b1

`endif
